// >>> rtl/pag_pkg.sv
// Package with register map, field positions, reset values and carrier types of the port block.
package pag_pkg;

  localparam int unsigned PAG_AW = 8;
  localparam int unsigned PAG_PW = 8;

  localparam logic [7:0] PAG_OFF_LEVEL = 8'h00;
  localparam logic [7:0] PAG_OFF_DIR = 8'h04;
  localparam logic [7:0] PAG_OFF_LATCH = 8'h08;
  localparam logic [7:0] PAG_OFF_ANSEL = 8'h0c;
  localparam logic [7:0] PAG_OFF_APF = 8'h10;

  localparam logic [7:0] PAG_DIR_RST = 8'hff;
  localparam logic [7:0] PAG_LATCH_RST = 8'h00;
  localparam logic [7:0] PAG_ANSEL_RST = 8'hff;
  localparam logic [7:0] PAG_APF_RST = 8'h00;
  localparam logic [7:0] PAG_APF_MASK = 8'h23;
  localparam logic [7:0] PAG_DIR_FORCE = 8'h08;

  localparam int unsigned PAG_BIT_SS = 5;
  localparam int unsigned PAG_BIT_GRDB = 1;
  localparam int unsigned PAG_BIT_GRDA = 0;
  localparam int unsigned PAG_SS_PIN_SET = 0;
  localparam int unsigned PAG_SS_PIN_CLR = 5;

  localparam int unsigned PAG_G_A1 = 0;
  localparam int unsigned PAG_G_A2 = 1;
  localparam int unsigned PAG_G_B1 = 2;
  localparam int unsigned PAG_G_B2 = 3;

  localparam int unsigned PAG_PB4 = 0;
  localparam int unsigned PAG_PB5 = 1;
  localparam int unsigned PAG_PB6 = 2;
  localparam int unsigned PAG_PB7 = 3;

  typedef enum logic [1:0] {
    PAG_ST_IDLE = 2'b00,
    PAG_ST_ANSWER = 2'b01
  } pag_apb_e;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
  } pag_pad_s;

  typedef struct packed {
    logic [3:0] val;
    logic [3:0] en;
  } pag_drive_s;

endpackage

// >>> rtl/pag_port.sv
// Port A general-purpose I/O with analog select, APB registers and pin steering.
//
// Notes on behaviour
// - Writing the latch register or the pin-level register both update the latch.
// - Latch register reads stored latch; pin-level register reads actual pin levels.
// - Direction 1 makes a pin input, driver off; 0 drives the latch value.
// - Pin three is input only; its direction bit always reads one.
// - A set analog-select bit disables that pin's digital input buffer.
// - Digital reads of an analog-selected pin always return zero.
// - Analog select leaves outputs alone; direction still controls the driver.
// - All analog-select bits come up set after reset.
// - Port writes are read-modify-write: pin levels read, modified, written to latch; a level write with pstrb[0] loads pwdata, one without loads dig_in.
// - An enabled peripheral takes over the pin output; the pin stays readable.
// - Bit five steers slave select to pin zero when set, pin five when clear.
// - Bit one set puts guard B one on pin seven, two on six; clear swaps.
// - Bit zero set puts guard A one on pin five, two on four; clear swaps.
// - Steering never touches direction values; overrides follow function, others unaffected.
// - Steering register unused bits read zero; its three bits reset to zero.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns
module pag_port (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [7:0] pa_pin_in,
  output pag_pkg::pag_pad_s pa_pad,
  output logic [7:0] pa_inbuf_dis,
  input logic [7:0] periph_out,
  input logic [7:0] periph_en,
  input pag_pkg::pag_drive_s guard_in,
  output pag_pkg::pag_drive_s pb_guard,
  output logic ss1_level
);

  pag_pkg::pag_apb_e state;
  pag_pkg::pag_apb_e next_state;

  logic [7:0] dir;
  logic [7:0] next_dir;
  logic [7:0] latch;
  logic [7:0] next_latch;
  logic [7:0] ansel;
  logic [7:0] next_ansel;
  logic [7:0] apf;
  logic [7:0] next_apf;

  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  pag_pkg::pag_pad_s next_pa_pad;
  logic [7:0] next_pa_inbuf_dis;
  pag_pkg::pag_drive_s next_pb_guard;
  logic next_ss1_level;

  logic [7:0] pin_sync;
  logic [7:0] dig_in;
  logic [7:0] dir_eff;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic commit;
  logic wr_level;
  logic wr_dir;
  logic wr_latch;
  logic wr_ansel;
  logic wr_apf;

  // Pin levels are brought into the clock domain before anyone reads them.
  pag_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(pa_pin_in),
    .q(pin_sync)
  );

  // Digital view of the pins and the effective direction.
  always_comb begin
    dig_in = pin_sync & ~ansel;
    dir_eff = dir | pag_pkg::PAG_DIR_FORCE;
  end

  // Address decode and read data selection.
  always_comb begin
    addr_hit = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      pag_pkg::PAG_OFF_LEVEL: begin
        rd_byte = dig_in;
      end
      pag_pkg::PAG_OFF_DIR: begin
        rd_byte = dir_eff;
      end
      pag_pkg::PAG_OFF_LATCH: begin
        rd_byte = latch;
      end
      pag_pkg::PAG_OFF_ANSEL: begin
        rd_byte = ansel;
      end
      pag_pkg::PAG_OFF_APF: begin
        rd_byte = apf & pag_pkg::PAG_APF_MASK;
      end
      default: begin
        addr_hit = 1'b0;
        rd_byte = 8'h00;
      end
    endcase
  end

  // Bus state machine: one wait cycle, then pready for one cycle.
  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (state)
      pag_pkg::PAG_ST_IDLE: begin
        if (psel && penable) begin
          next_state = pag_pkg::PAG_ST_ANSWER;
          next_pready = 1'b1;
          next_pslverr = ~addr_hit;
          next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
      end
      pag_pkg::PAG_ST_ANSWER: begin
        next_state = pag_pkg::PAG_ST_IDLE;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
      end
      default: begin
        next_state = pag_pkg::PAG_ST_IDLE;
      end
    endcase
  end

  // A write commits at the edge where the master sees pready high.
  always_comb begin
    commit = (state == pag_pkg::PAG_ST_ANSWER) && psel && penable && pwrite && addr_hit;
    wr_level = commit && (paddr == pag_pkg::PAG_OFF_LEVEL);
    wr_dir = commit && pstrb[0] && (paddr == pag_pkg::PAG_OFF_DIR);
    wr_latch = commit && pstrb[0] && (paddr == pag_pkg::PAG_OFF_LATCH);
    wr_ansel = commit && pstrb[0] && (paddr == pag_pkg::PAG_OFF_ANSEL);
    wr_apf = commit && pstrb[0] && (paddr == pag_pkg::PAG_OFF_APF);
  end

  // Next values of the software registers.
  always_comb begin
    next_dir = dir;
    next_latch = latch;
    next_ansel = ansel;
    next_apf = apf;
    if (wr_level) begin
      next_latch = pstrb[0] ? pwdata[7:0] : dig_in;
    end
    if (wr_latch) begin
      next_latch = pwdata[7:0];
    end
    if (wr_dir) begin
      next_dir = pwdata[7:0];
    end
    if (wr_ansel) begin
      next_ansel = pwdata[7:0];
    end
    if (wr_apf) begin
      next_apf = pwdata[7:0] & pag_pkg::PAG_APF_MASK;
    end
  end

  // Per-pin output value and driver enable.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always_comb begin
        next_pa_pad.level[gi] = periph_en[gi] ? periph_out[gi] : latch[gi];
        next_pa_pad.oe_n[gi] = dir_eff[gi];
      end
    end
  endgenerate

  // Input buffer disable follows analog select only; outputs ignore it.
  always_comb begin
    next_pa_inbuf_dis = ansel;
  end

  // Steering of slave select and guard ring drives.
  always_comb begin
    next_ss1_level = apf[pag_pkg::PAG_BIT_SS] ? dig_in[pag_pkg::PAG_SS_PIN_SET] :
                     dig_in[pag_pkg::PAG_SS_PIN_CLR];
    next_pb_guard.val = 4'h0;
    next_pb_guard.en = 4'h0;
    if (apf[pag_pkg::PAG_BIT_GRDA]) begin
      next_pb_guard.val[pag_pkg::PAG_PB5] = guard_in.val[pag_pkg::PAG_G_A1];
      next_pb_guard.en[pag_pkg::PAG_PB5] = guard_in.en[pag_pkg::PAG_G_A1];
      next_pb_guard.val[pag_pkg::PAG_PB4] = guard_in.val[pag_pkg::PAG_G_A2];
      next_pb_guard.en[pag_pkg::PAG_PB4] = guard_in.en[pag_pkg::PAG_G_A2];
    end else begin
      next_pb_guard.val[pag_pkg::PAG_PB4] = guard_in.val[pag_pkg::PAG_G_A1];
      next_pb_guard.en[pag_pkg::PAG_PB4] = guard_in.en[pag_pkg::PAG_G_A1];
      next_pb_guard.val[pag_pkg::PAG_PB5] = guard_in.val[pag_pkg::PAG_G_A2];
      next_pb_guard.en[pag_pkg::PAG_PB5] = guard_in.en[pag_pkg::PAG_G_A2];
    end
    if (apf[pag_pkg::PAG_BIT_GRDB]) begin
      next_pb_guard.val[pag_pkg::PAG_PB7] = guard_in.val[pag_pkg::PAG_G_B1];
      next_pb_guard.en[pag_pkg::PAG_PB7] = guard_in.en[pag_pkg::PAG_G_B1];
      next_pb_guard.val[pag_pkg::PAG_PB6] = guard_in.val[pag_pkg::PAG_G_B2];
      next_pb_guard.en[pag_pkg::PAG_PB6] = guard_in.en[pag_pkg::PAG_G_B2];
    end else begin
      next_pb_guard.val[pag_pkg::PAG_PB6] = guard_in.val[pag_pkg::PAG_G_B1];
      next_pb_guard.en[pag_pkg::PAG_PB6] = guard_in.en[pag_pkg::PAG_G_B1];
      next_pb_guard.val[pag_pkg::PAG_PB7] = guard_in.val[pag_pkg::PAG_G_B2];
      next_pb_guard.en[pag_pkg::PAG_PB7] = guard_in.en[pag_pkg::PAG_G_B2];
    end
  end

  // Bus state and answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pag_pkg::PAG_ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      state <= next_state;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // Software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir <= pag_pkg::PAG_DIR_RST;
      latch <= pag_pkg::PAG_LATCH_RST;
      ansel <= pag_pkg::PAG_ANSEL_RST;
      apf <= pag_pkg::PAG_APF_RST;
    end else if (ce) begin
      dir <= next_dir;
      latch <= next_latch;
      ansel <= next_ansel;
      apf <= next_apf;
    end
  end

  // Registered pin-side outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_pad.level <= 8'h00;
      pa_pad.oe_n <= 8'hff;
      pa_inbuf_dis <= pag_pkg::PAG_ANSEL_RST;
      pb_guard.val <= 4'h0;
      pb_guard.en <= 4'h0;
      ss1_level <= 1'b0;
    end else if (ce) begin
      pa_pad <= next_pa_pad;
      pa_inbuf_dis <= next_pa_inbuf_dis;
      pb_guard <= next_pb_guard;
      ss1_level <= next_ss1_level;
    end
  end

endmodule // pag_port

// >>> rtl/pag_sync.sv
// Two-flop synchroniser for the port A pin levels.
`timescale 1ns/1ns
module pag_sync (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic [7:0] d,
  output logic [7:0] q
);

  logic [7:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 8'h00;
      q <= 8'h00;
    end else if (ce) begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule // pag_sync

// >>> sim/pag_pins.sv
// Pin model: driven pins show the pad value, released pins show the outside level.
`timescale 1ns/1ns
module pag_pins (
  input pag_pkg::pag_pad_s pad,
  input logic [7:0] ext,
  output logic [7:0] pin
);
  assign pin = (pad.oe_n & ext) | (~pad.oe_n & pad.level);
endmodule // pag_pins

// >>> sim/pag_port_asserts.sv
// Checker for bus timing and pad outputs of the port block.
`timescale 1ns/1ns
module pag_port_asserts (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic [7:0] pa_inbuf_dis,
  input pag_pkg::pag_pad_s pa_pad,
  input logic [7:0] periph_out,
  input logic [7:0] periph_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  rdy_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  rd_high_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  pin_three_a: assert property (pa_pad.oe_n[3])
    else $error("pin three driven");
  reset_out_a: assert property ($rose(presetn) |-> pa_inbuf_dis == 8'hff && pa_pad.oe_n == 8'hff)
    else $error("wrong values after reset");
  ansel_wr_a: assert property (wr && paddr == 8'h0c |-> ##2 pa_inbuf_dis == $past(pwdata[7:0], 2))
    else $error("input buffer disable wrong");
  dir_wr_a: assert property (wr && paddr == 8'h04 |-> ##2 pa_pad.oe_n == ($past(pwdata[7:0], 2) | 8'h08))
    else $error("driver enable wrong");
  latch_wr_a: assert property (wr && (paddr == 8'h08 || paddr == 8'h00) |-> ##2
    pa_pad.level == (($past(periph_en) & $past(periph_out)) | (~$past(periph_en) & $past(pwdata[7:0], 2))))
    else $error("pad level wrong");
endmodule // pag_port_asserts
bind pag_port pag_port_asserts pag_port_asserts_inst (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pa_inbuf_dis, .pa_pad, .periph_out,
  .periph_en);

// >>> sim/port_a_gpio_with_pin_steering_bench.sv
// Self-checking bench for the port A block.
`timescale 1ns/1ns
module port_a_gpio_with_pin_steering_bench;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, ext = 8'h00, pin, periph_out = 8'h00, periph_en = 8'h00;
  logic [7:0] pa_inbuf_dis;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, ss1_level, er;
  pag_pkg::pag_pad_s pa_pad;
  pag_pkg::pag_drive_s guard_in = 8'h00, pb_guard;
  int n_fail = 0, n_checks = 0;
  always #2 pclk = ~pclk;
  pag_port pag_port_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pa_pin_in(pin), .pa_pad, .pa_inbuf_dis, .periph_out,
    .periph_en, .guard_in, .pb_guard, .ss1_level);
  pag_pins pag_pins_inst (.pad(pa_pad), .ext, .pin);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(nm, rd, e);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #4000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("dir", 8'h04, 32'hff);
    rc("latch", 8'h08, 32'h0);
    rc("ansel", 8'h0c, 32'hff);
    rc("steer", 8'h10, 32'h0);
    ext <= 8'h5a;
    rc("level", 8'h00, 32'h0);
    wr(8'h0c, 32'h0);
    rc("level", 8'h00, 32'h5a);
    wr(8'h00, 32'h33);
    rc("latch", 8'h08, 32'h33);
    wr(8'h08, 32'h3c);
    wr(8'h04, 32'h0);
    rc("dir", 8'h04, 32'h08);
    rc("level", 8'h00, 32'h3c);
    periph_en <= 8'h02;
    periph_out <= 8'h02;
    repeat (3) @(posedge pclk);
    chk("pad", pa_pad.level, 32'h3e);
    periph_en <= 8'h00;
    wr(8'h04, 32'hff);
    ext <= 8'ha5;
    repeat (4) @(posedge pclk);
    xfer(1'b1, 8'h00, 32'h0, 4'h0);
    rc("latch", 8'h08, 32'ha5);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'hff);
    chk("oe", pa_pad.oe_n, 32'h08);
    chk("inbuf", pa_inbuf_dis, 32'hff);
    rc("level", 8'h00, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'hff);
    ext <= 8'h01;
    guard_in <= 8'h5f;
    wr(8'h10, 32'hff);
    rc("steer", 8'h10, 32'h23);
    chk("guard", pb_guard, 32'haf);
    chk("ss", ss1_level, 32'h1);
    rc("dir", 8'h04, 32'hff);
    wr(8'h10, 32'h0);
    chk("guard", pb_guard, 32'h5f);
    chk("ss", ss1_level, 32'h0);
    ce <= 1'b0;
    ext <= 8'h20;
    repeat (4) @(posedge pclk);
    chk("ss", ss1_level, 32'h0);
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ss", ss1_level, 32'h1);
    xfer(1'b0, 8'h14, 32'h0, 4'h0);
    chk("err", er, 32'h1);
    chk("rdata", rd, 32'h0);
    end_sim;
  end
endmodule // port_a_gpio_with_pin_steering_bench
